// ===== pkg/apc_pkg.sv
// shared constants and carrier types for the audio port configuration block
package apc_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_PORT_CONFIG = 8'h09;
   localparam logic [7:0] IDX_OFF_TIME_LOW = 8'h0b;
   localparam logic [7:0] IDX_OFF_TIME_HIGH = 8'h0c;
   localparam logic [7:0] IDX_ON_TIME = 8'h0d;
   localparam logic [7:0] IDX_INPUT_REF = 8'h0e;
   localparam logic [7:0] IDX_OUTPUT_REF = 8'h0f;
   localparam logic [7:0] IDX_PORT_STATUS = 8'h10;

   // config value after reset, frame sync select bit filled by the strap
   localparam logic [7:0] PORT_CONFIG_RESET = 8'h24;
   localparam logic [7:0] DETECTOR_RESET = 8'h00;

   // frame geometry in serial clock bits
   localparam int CHANNEL_BITS = 16;
   localparam int FRAME_BITS = 32;

   // clocks after reset release at which the serial clock strap is taken
   localparam logic [1:0] STRAP_CYCLES = 2'h3;

   // audio interface configuration register layout, msb first
   typedef struct packed {
      logic loopback;       // adc to dac internal loop, stored only
      logic rxSecond;       // receive slot select, stored only
      logic reserved5;      // reads back as written, resets to 1
      logic master;         // generate frame timing (long sync only)
      logic tristateEnable; // output_tristate_enable
      logic txFirst;        // send sample in first channel
      logic txSecond;       // send sample in second channel
      logic frameSyncSelect;// 1 short_sync_mode, 0 long_sync_mode
   } apc_config_t;

   // detector parameter set handed to the detector core
   typedef struct packed {
      logic [15:0] offTime;
      logic [7:0] onTime;
      logic [7:0] inputRef;
      logic [7:0] outputRef;
   } apc_detector_t;

   // serial frame progress
   typedef enum logic [1:0] {
      FRM_IDLE = 2'b00,
      FRM_WAIT = 2'b01,
      FRM_RUN = 2'b10
   } apc_frame_t;

endpackage

// ===== rtl/apc_audio_port.sv
// audio serial port slot, drive and frame sync control with detector registers
//
// Function
// RULE1 - tristate off: drive output through whole frame
// RULE2 - tristate on: drive only channels with data
// RULE3 - first channel send bit, resets to one
// RULE4 - second channel send bit, resets to zero
// RULE5 - select bit: one short sync, zero long
// RULE6 - serial clock strap sets sync select default
// RULE7 - sixteen bit off time, two bytes, zero reset
// RULE8 - on time byte at 0x0D, zero reset
// RULE9 - input path reference byte at 0x0E
// RULE10 - playback path reference byte at 0x0F
// RULE11 - master timing only under long sync
// RULE12 - config register at 0x09, reset 0x25/0x24
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
module apc_audio_port
   import apc_pkg::*;
#(
   parameter int ADR_WIDTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_WIDTH-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial link pins
   input wire logic serialClockPin,
   input wire logic frameSyncIn,
   output logic frameSyncOut,
   output logic frameSyncOen,
   output logic serialAudioOut,
   output logic serialAudioOen,
   // sample source on the local clock
   input wire logic [15:0] txSample,
   output logic sampleTaken,
   // configuration seen by the rest of the codec
   output apc_config_t portConfig,
   output apc_detector_t detectorParams,
   output logic masterActive
);

   // synchronised pins
   logic [1:0] pinSync;        // {frame sync, serial clock}
   logic sckSync;              // serial clock after two flops
   logic fsSync;               // frame sync after two flops
   logic sckPrev;              // last sampled serial clock level
   logic sckRise;              // rising edge seen this cycle
   logic fsPrev;               // frame sync at the previous bit
   logic fsLevel;              // frame sync as the port sees it

   // startup strap
   logic [1:0] strapCnt;       // counts clocks after reset release
   logic strapLoad;            // one cycle to take the strap

   // bus decode
   logic busReq;               // live request not yet acknowledged
   logic [ADR_WIDTH-3:0] regIdx; // word index
   logic wordAligned;          // low address bits zero
   logic wrLane0;              // write with lane zero enabled
   logic [31:0] next_rdData;   // read mux result

   // frame engine
   apc_frame_t frameState;     // idle, waiting one bit, running
   logic [4:0] bitCnt;         // bit position in the frame
   logic [15:0] sampleHold;    // sample frozen for this frame
   logic chanEnable;           // current channel carries data
   logic frameStart;           // begin a frame at this bit
   logic fsNewHigh;            // frame sync went high at this bit

   apc_sync #(
      .WIDTH(2)
   ) u_pinSync (
      .clk(clk),
      .rstn(rstn),
      .asyncIn({frameSyncIn, serialClockPin}),
      .syncOut(pinSync)
   );

   assign sckSync = pinSync[0];
   assign fsSync = pinSync[1];
   assign sckRise = sckSync && !sckPrev;

   // master drives its own sync, so the port follows what it drives
   assign fsLevel = masterActive ? frameSyncOut : fsSync;
   assign fsNewHigh = fsLevel && !fsPrev;

   // wishbone request decode
   assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign regIdx = wb_adr_i[ADR_WIDTH-1:2];
   assign wordAligned = (wb_adr_i[1:0] == 2'h0);
   // a write lands on the edge where the master samples ack, data still held there
   assign wrLane0 = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wordAligned;

   // serial clock edge tracking, runs on every clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sckPrev <= 1'b0;
      end else begin
         sckPrev <= sckSync;
      end
   end

   // strap window: the synchroniser needs two clocks to fill first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strapCnt <= 2'h0;
      end else if (strapCnt != STRAP_CYCLES) begin
         strapCnt <= strapCnt + 2'h1;
      end
   end

   assign strapLoad = (strapCnt == STRAP_CYCLES - 2'h1);

   // audio interface configuration register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         portConfig <= apc_config_t'(PORT_CONFIG_RESET); // RULE12 RULE3 RULE4
      end else begin
         if (strapLoad) begin
            // low clock pin picks short sync, high picks long
            portConfig.frameSyncSelect <= !sckSync; // RULE6
         end
         // a software write after the strap always wins
         if (wrLane0 && regIdx == IDX_PORT_CONFIG[ADR_WIDTH-3:0]) begin
            portConfig <= apc_config_t'(wb_dat_i[7:0]); // RULE12
         end
      end
   end

   // detector parameter registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         detectorParams.offTime <= {DETECTOR_RESET, DETECTOR_RESET}; // RULE7
         detectorParams.onTime <= DETECTOR_RESET; // RULE8
         detectorParams.inputRef <= DETECTOR_RESET; // RULE9
         detectorParams.outputRef <= DETECTOR_RESET; // RULE10
      end else if (wrLane0) begin
         case (regIdx)
            IDX_OFF_TIME_LOW[ADR_WIDTH-3:0]: begin
               detectorParams.offTime[7:0] <= wb_dat_i[7:0]; // RULE7
            end
            IDX_OFF_TIME_HIGH[ADR_WIDTH-3:0]: begin
               detectorParams.offTime[15:8] <= wb_dat_i[7:0]; // RULE7
            end
            IDX_ON_TIME[ADR_WIDTH-3:0]: begin
               detectorParams.onTime <= wb_dat_i[7:0]; // RULE8
            end
            IDX_INPUT_REF[ADR_WIDTH-3:0]: begin
               detectorParams.inputRef <= wb_dat_i[7:0]; // RULE9
            end
            IDX_OUTPUT_REF[ADR_WIDTH-3:0]: begin
               detectorParams.outputRef <= wb_dat_i[7:0]; // RULE10
            end
            default: begin
               // other indices hold no detector state
            end
         endcase
      end
   end

   // read mux; unmapped or misaligned addresses read as zero
   always_comb begin
      next_rdData = 32'h0;
      if (wordAligned) begin
         case (regIdx)
            IDX_PORT_CONFIG[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = portConfig;
            end
            IDX_OFF_TIME_LOW[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = detectorParams.offTime[7:0];
            end
            IDX_OFF_TIME_HIGH[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = detectorParams.offTime[15:8];
            end
            IDX_ON_TIME[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = detectorParams.onTime;
            end
            IDX_INPUT_REF[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = detectorParams.inputRef;
            end
            IDX_OUTPUT_REF[ADR_WIDTH-3:0]: begin
               next_rdData[7:0] = detectorParams.outputRef;
            end
            IDX_PORT_STATUS[ADR_WIDTH-3:0]: begin
               // live port state for software
               next_rdData[4:0] = bitCnt;
               next_rdData[6:5] = frameState;
               next_rdData[7] = masterActive;
            end
            default: begin
               next_rdData = 32'h0;
            end
         endcase
      end
   end

   // bus answer: one cycle after the request, ack dropped the cycle after
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= busReq;
         if (busReq && !wb_we_i) begin
            wb_dat_o <= next_rdData;
         end
      end
   end

   // master timing is refused under short sync, the port then stays slave
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         masterActive <= 1'b0;
      end else begin
         masterActive <= portConfig.master && !portConfig.frameSyncSelect; // RULE11 RULE5
      end
   end

   // frame sync history, taken once per serial bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fsPrev <= 1'b0;
      end else if (sckRise) begin
         fsPrev <= fsLevel;
      end
   end

   // long sync: data starts with the sync bit; short: one bit later
   always_comb begin
      frameStart = 1'b0;
      if (frameState == FRM_WAIT) begin
         frameStart = 1'b1;
      end else if (fsNewHigh && !portConfig.frameSyncSelect) begin
         frameStart = 1'b1; // RULE5
      end
   end

   // frame sequencer, advances on serial clock rising edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frameState <= FRM_IDLE;
         bitCnt <= 5'h0;
      end else if (sckRise) begin
         case (frameState)
            FRM_IDLE: begin
               if (frameStart) begin
                  frameState <= FRM_RUN;
                  bitCnt <= 5'h0;
               end else if (fsNewHigh) begin
                  // short sync pulse; data follows next bit
                  frameState <= FRM_WAIT; // RULE5
               end
            end
            FRM_WAIT: begin
               frameState <= FRM_RUN;
               bitCnt <= 5'h0;
            end
            FRM_RUN: begin
               if (bitCnt == 5'(FRAME_BITS - 1)) begin
                  // a long sync landing on the last bit chains the next frame
                  frameState <= frameStart ? FRM_RUN : FRM_IDLE;
                  bitCnt <= 5'h0;
               end else begin
                  bitCnt <= bitCnt + 5'h1;
               end
            end
            default: begin
               frameState <= FRM_IDLE;
               bitCnt <= 5'h0;
            end
         endcase
      end
   end

   // master sync: high from the idle bit through the first channel, one idle bit between frames
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frameSyncOut <= 1'b0;
         frameSyncOen <= 1'b1;
      end else begin
         frameSyncOen <= !masterActive; // RULE11
         if (!masterActive) begin
            frameSyncOut <= 1'b0;
         end else if (sckRise) begin
            // raise at the last bit so the next frame opens with it
            if (frameState != FRM_RUN || bitCnt == 5'(FRAME_BITS - 1)) begin
               frameSyncOut <= 1'b1; // RULE11
            end else if (bitCnt == 5'(CHANNEL_BITS - 1)) begin
               frameSyncOut <= 1'b0;
            end
         end
      end
   end

   // sample capture at frame start; a late sample waits a whole frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sampleHold <= 16'h0;
         sampleTaken <= 1'b0;
      end else begin
         sampleTaken <= 1'b0;
         if (sckRise && frameStart) begin
            sampleHold <= txSample;
            sampleTaken <= 1'b1;
         end
      end
   end

   // channel zero is the first slot after sync, channel one the second
   assign chanEnable = bitCnt[4] ? portConfig.txSecond : portConfig.txFirst; // RULE3 RULE4

   // serial data and its enable, msb first, updated on rising edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serialAudioOut <= 1'b0;
         serialAudioOen <= 1'b1;
      end else begin
         if (!portConfig.tristateEnable) begin
            serialAudioOen <= 1'b0; // RULE1
         end else begin
            serialAudioOen <= !(frameState == FRM_RUN && chanEnable); // RULE2
         end
         if (frameState == FRM_RUN && chanEnable) begin
            serialAudioOut <= sampleHold[4'hf - bitCnt[3:0]]; // RULE3 RULE4
         end else begin
            // empty slot sends zeros when still driven
            serialAudioOut <= 1'b0;
         end
      end
   end

endmodule

// ===== rtl/apc_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module apc_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   // first stage is read by the second stage only
   logic [WIDTH-1:0] meta;

   // plain two stage chain, constants under reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         syncOut <= '0;
      end else begin
         meta <= asyncIn;
         syncOut <= meta;
      end
   end
endmodule

// ===== tb/apc_audio_port_sva.sv
// bound checker for the audio port configuration block
`timescale 1ns/1ns
module apc_audio_port_sva
   import apc_pkg::*;
#(
   parameter int ADR_WIDTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_WIDTH-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic serialClockPin,
   input wire logic frameSyncOen,
   input wire logic frameSyncOut,
   input wire logic serialAudioOen,
   input wire apc_config_t portConfig,
   input wire apc_detector_t detectorParams,
   input wire logic masterActive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [2:0] relCnt; // edges since reset release, saturates
   // counts up to seven and stops, so the strap check fires once a reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         relCnt <= 3'h0;
      end else if (relCnt != 3'h7) begin
         relCnt <= relCnt + 3'h1;
      end
   end
   // request the slave takes at this edge
   sequence wbTake;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // taken write with low byte enabled to one address
   sequence wbWrite(logic [7:0] adr);
      wbTake ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == adr);
   endsequence
   // stored byte shows two edges later whichever edge stores it
   property storeP(logic [7:0] adr, logic [7:0] field);
      wbWrite(adr) |-> ##2 field == $past(wb_dat_i[7:0], 2);
   endproperty
   ack_pulse_a: assert property (wbTake |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse after request");
   reset_values_a: assert property ($rose(rstn) |->
      portConfig == PORT_CONFIG_RESET && detectorParams == 40'h0)
      else $error("reset values wrong");
   strap_default_a: assert property (relCnt == 3'h5 |->
      portConfig.frameSyncSelect == !serialClockPin)
      else $error("strap not applied");
   drive_always_a: assert property (!portConfig.tristateEnable |=> !serialAudioOen)
      else $error("data out released with tristate off");
   idle_release_a: assert property (portConfig.tristateEnable && !portConfig.txFirst
      && !portConfig.txSecond |=> serialAudioOen)
      else $error("data out driven with no channel");
   master_long_a: assert property (portConfig.master && !portConfig.frameSyncSelect
      |=> masterActive)
      else $error("master timing not active");
   short_slave_a: assert property (portConfig.frameSyncSelect
      |=> !masterActive ##1 frameSyncOen)
      else $error("short sync not slave");
   slave_sync_low_a: assert property (!masterActive |=> !frameSyncOut)
      else $error("sync out driven while slave");
   config_store_a: assert property (storeP(8'h24, portConfig))
      else $error("config write lost");
   off_low_a: assert property (storeP(8'h2c, detectorParams.offTime[7:0]))
      else $error("off time low write lost");
   off_high_a: assert property (storeP(8'h30, detectorParams.offTime[15:8]))
      else $error("off time high write lost");
   on_time_a: assert property (storeP(8'h34, detectorParams.onTime))
      else $error("on time write lost");
   in_ref_a: assert property (storeP(8'h38, detectorParams.inputRef))
      else $error("input reference write lost");
   out_ref_a: assert property (storeP(8'h3c, detectorParams.outputRef))
      else $error("output reference write lost");
endmodule
bind apc_audio_port apc_audio_port_sva #(.ADR_WIDTH(ADR_WIDTH)) chk (.clk(clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .serialClockPin(serialClockPin), .frameSyncOen(frameSyncOen), .frameSyncOut(frameSyncOut),
   .serialAudioOen(serialAudioOen), .portConfig(portConfig),
   .detectorParams(detectorParams), .masterActive(masterActive));

// ===== tb/apc_link_model.sv
// far end model: bit clock, long frame sync, capture of the data out pin
`timescale 1ns/1ns
module apc_link_model (
   input wire logic idleLevel,
   input wire logic serialAudioOut,
   input wire logic serialAudioOen,
   output logic sckPin,
   output logic sync,
   output logic [31:0] frameData,
   output logic [31:0] frameOen,
   output logic frameDone
);
   logic sck; // bit clock inside a frame
   logic running; // frame in progress
   // clock stands at the strap level outside frames
   assign sckPin = running ? sck : idleLevel;
   initial begin
      sck = 1'b1;
      sync = 1'b0;
      running = 1'b0;
      frameDone = 1'b0;
      frameData = 32'h0;
      frameOen = 32'h0;
   end
   // one long sync frame; bit n is taken just before rise n+1
   task automatic runFrame;
      // keep every pin change clear of the sampling clock edge
      #10;
      running = 1'b1;
      for (int k = 0; k < 34; k++) begin
         sck = 1'b0;
         sync = (k < 16);
         #200;
         if (k >= 1 && k <= 32) begin
            frameOen[32-k] = serialAudioOen;
            // released bits read as zero
            frameData[32-k] = serialAudioOut & ~serialAudioOen;
         end
         sck = 1'b1;
         #200;
      end
      running = 1'b0;
      frameDone = 1'b1;
      #10 frameDone = 1'b0;
   endtask
endmodule

// ===== tb/audio_port_slot_and_detector_config_tb.sv
// self-checking bench for the audio port configuration block
`timescale 1ns/1ns
module audio_port_slot_and_detector_config_tb
   import apc_pkg::*;
;
   logic clk, rstn, wbCyc, wbStb, wbWe, idleLevel, wbAck, sck, syncIn, frameDone;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, frameData, frameOen;
   logic [31:0] expQ[$]; // expected results in order
   logic serialAudioOut, serialAudioOen, masterActive, sampleTaken;
   int takenCnt = 0; // sample latch pulses seen so far
   logic [15:0] txSample;
   apc_config_t portConfig;
   apc_detector_t detectorParams;
   int numErrors = 0;
   int comparisons = 0;
   logic [7:0] idxTab[7] = '{8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h3f};
   logic [7:0] cfgTab[6] = '{8'h24, 8'h22, 8'h2c, 8'h2a, 8'h28, 8'h26};
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   apc_audio_port dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .serialClockPin(sck), .frameSyncIn(syncIn),
      .frameSyncOut(), .frameSyncOen(), .serialAudioOut(serialAudioOut),
      .serialAudioOen(serialAudioOen),
      .txSample(txSample), .sampleTaken(sampleTaken), .portConfig(portConfig),
      .detectorParams(detectorParams), .masterActive(masterActive));
   apc_link_model link (.idleLevel(idleLevel), .serialAudioOut(serialAudioOut),
      .serialAudioOen(serialAudioOen), .sckPin(sck), .sync(syncIn), .frameData(frameData),
      .frameOen(frameOen), .frameDone(frameDone));
   // single comparison point
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // oldest note against what appeared; a missing note is a mismatch
   task automatic takeNote(input logic [31:0] seen);
      // bit 31 forced apart so an unknown value cannot slip through
      if (expQ.size() == 0) check({1'b1, seen[30:0]}, {1'b0, seen[30:0]});
      else check(seen, expQ.pop_front());
   endtask
   task automatic endOfTest;
      $display("errors %0d comparisons %0d", numErrors, comparisons);
      if (numErrors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx[5:0], 2'b00};
      wbDatI <= {24'h0, wd};
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) begin
         numErrors++;
         endOfTest();
      end
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic rdExp(input logic [7:0] idx, input logic [31:0] exp);
      expQ.push_back(exp);
      wbXfer(1'b0, idx, 8'h0);
   endtask
   // read answers and finished frames are checked as they appear
   always @(posedge clk) begin
      if (wbAck === 1'b1 && wbWe === 1'b0) takeNote(wbDatO);
   end
   always @(posedge frameDone) begin
      takeNote(frameData);
      takeNote(frameOen);
   end
   // one latch pulse expected per frame
   always @(posedge clk) begin
      if (sampleTaken === 1'b1) takenCnt++;
   end
   initial begin
      logic [7:0] wv[7];
      logic [7:0] c;
      logic [15:0] s;
      int seed;
      rstn = 1'b0;
      {wbCyc, wbStb, wbWe} = 3'h0;
      wbAdr = 8'h0;
      wbSel = 4'hf;
      wbDatI = 32'h0;
      idleLevel = 1'b1;
      txSample = 16'h0;
      seed = $urandom(87420);
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         rdExp(idxTab[i], (i == 0) ? 32'h24 : 32'h0);
      end
      for (int i = 1; i < 6; i++) begin
         wv[i] = 8'($urandom);
         wbXfer(1'b1, idxTab[i], wv[i]);
         rdExp(idxTab[i], {24'h0, wv[i]});
      end
      check({16'h0, detectorParams.offTime}, {16'h0, wv[2], wv[1]});
      // every slot and drive mode, random sample each frame
      for (int i = 0; i < 6; i++) begin
         c = cfgTab[i];
         s = 16'($urandom);
         wbXfer(1'b1, 8'h09, c);
         txSample <= s;
         expQ.push_back({c[2] ? s : 16'h0, c[1] ? s : 16'h0});
         expQ.push_back(c[3] ? {{16{~c[2]}}, {16{~c[1]}}} : 32'h0);
         link.runFrame();
         check(32'(takenCnt), 32'(i + 1));
      end
      wbXfer(1'b1, 8'h09, 8'h34);
      repeat (3) @(posedge clk);
      check({31'h0, masterActive}, 32'h1);
      wbXfer(1'b1, 8'h09, 8'h35);
      repeat (3) @(posedge clk);
      check({31'h0, masterActive}, 32'h0);
      // second reset with the clock pin low picks short sync
      rstn <= 1'b0;
      idleLevel <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      rdExp(8'h09, 32'h25);
      idleLevel <= 1'b1;
      repeat (2) @(posedge clk);
      check(32'(expQ.size()), 32'h0);
      endOfTest();
   end
endmodule
